// ===== hdl/dsc_core.sv
`timescale 1ns/1ps
`include "dsc_regs.svh"
// Behaviour
// - while running, sleep only after speed stays below threshold for full delay.
// - band zero: wake when speed reaches threshold plus 2 Hz.
// - band nonzero: wake when feedback departs setpoint by band, by polarity.
// - band of zero disables feedback wake.
// - band compared in feedback units.
// - lowest reference (0 V or 4 mA) gives minimum frequency.
// - full scale reference gives maximum frequency.
// - linear interpolation between minimum and maximum.
// - minimum above maximum gives inverse operation.
// - one adjustable filter on both references.
// - frequency monitor proportional, 0-10 or 2-10 V, or disabled.
// - full-scale frequency gives exactly 10 V.
// - load monitor proportional, 0-10 or 2-10 V.
// - full-scale load gives 10 V.
// - load monitor uses load after multiplier.
// - input one: none, vref, iref, preset one, local, pot decrease.
// - input two: none, vref, iref, preset two, pot increase.
// - input three: none, vref, iref, preset three, local, reverse start.
// - with strip choice, local select closed means local, open remote.
// - input four normally-open fault trips on closure.
// - input four normally-closed fault trips on opening.
// - input four clear mode clears fault on closure.
// - clear mode ignores stop input as clear; keypad stop still clears.
// - speed back at or above threshold restarts delay.
// - start while stopped below threshold sleeps at once.
// - sleep status shown while sleeping.
module dsc_core #(
   parameter int SEC_CYCLES = `DSC_SEC_CYCLES
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [15:0] commanded_speed,
   input wire logic [15:0] low_speed_sleep_level,
   input wire logic [15:0] sleep_delay_time,
   input wire logic [15:0] wake_feedback_band,
   input wire logic [15:0] pid_feedback,
   input wire logic [15:0] pid_setpoint,
   input wire logic reverse_acting,
   input wire logic running,
   input wire logic start_cmd,
   input wire logic [9:0] voltage_ref_in,
   input wire logic [9:0] current_ref_in,
   input wire logic use_current_ref,
   input wire logic [3:0] analog_in_filter,
   input wire logic [15:0] ref_min_frequency,
   input wire logic [15:0] ref_max_frequency,
   input wire logic [15:0] output_frequency,
   input wire dsc_pkg::dsc_mon_e freq_monitor_range,
   input wire logic [15:0] freq_monitor_full_scale,
   input wire logic [15:0] drive_load,
   input wire logic [15:0] load_scale_factor,
   input wire dsc_pkg::dsc_mon_e load_monitor_range,
   input wire logic [15:0] load_monitor_full_scale,
   input wire dsc_pkg::dsc_fn_e prog_one_fn,
   input wire dsc_pkg::dsc_fn_e prog_two_fn,
   input wire dsc_pkg::dsc_fn_e prog_three_fn,
   input wire dsc_pkg::dsc_fn4_e prog_four_fn,
   input wire logic strip_mode_choice,
   input wire logic prog_input_one_n,
   input wire logic prog_input_two_n,
   input wire logic prog_input_three_n,
   input wire logic prog_input_four_n,
   input wire logic stop_input_n,
   input wire logic keypad_stop,
   output logic sleep_active,
   output logic sleep_status,
   output logic [15:0] ref_frequency,
   output logic [9:0] freq_monitor_out,
   output logic [9:0] load_monitor_out,
   output logic vref_select,
   output logic iref_select,
   output logic [2:0] preset_select,
   output logic local_mode,
   output logic pot_decrease_fn,
   output logic pot_increase_fn,
   output logic reverse_start_fn,
   output logic fault_active
);
   import dsc_pkg::*;

   typedef struct packed {
      logic [4:0] sy1;
      logic [4:0] sy2;
      logic [4:0] act;
      logic [1:0] ext_d;
      dsc_state_e st;
      logic [25:0] pre;
      logic [15:0] secs;
      logic [25:0] filt;
      logic [15:0] freq;
      logic [9:0] fmon;
      logic [9:0] lmon;
      logic fault;
      logic sleep;
   } dsc_s;

   dsc_s cur_reg, cur_next;

   // input code to the chosen monitor range, saturating at 10 V
   function automatic logic [9:0] mon_scale(input logic [15:0] val,
         input logic [15:0] full, input dsc_mon_e rng);
      logic [25:0] q;
      logic [9:0] span;
      logic [35:0] t;
      q = 26'h0;
      span = 10'h000;
      t = 36'h0;
      mon_scale = 10'h000;
      // full scale of zero leaves the output at its low end
      if (full != 16'h0000) begin
         q = ({10'h000, val} * {16'h0000, `DSC_DAC_FULL}) / {10'h000, full};
         if (q > {16'h0000, `DSC_DAC_FULL}) begin
            q = {16'h0000, `DSC_DAC_FULL};
         end
      end
      if (rng == DSC_MON_0_10) begin
         mon_scale = q[9:0];
      end else if (rng == DSC_MON_2_10) begin
         // live zero at 2 V, so a broken wire reads below range
         span = `DSC_DAC_FULL - `DSC_DAC_2V;
         t = {26'h0, span} * {10'h0, q};
         mon_scale = `DSC_DAC_2V + 10'(t / {26'h0, `DSC_DAC_FULL});
      end
   endfunction

   logic [9:0] ref_raw;
   logic [9:0] ref_pos;
   logic [9:0] ref_span;
   logic [9:0] filt_code;
   // working values of the combinational stage
   logic [31:0] load_scaled;
   logic below;
   logic wake_speed;
   logic wake_fb;
   logic [16:0] fb_lim;
   logic fb_active;
   logic [26:0] prod;
   logic clear_req;

   always_comb begin
      cur_next = cur_reg;
      // contacts are asynchronous: three stages (sy1, sy2, act) before any decode
      cur_next.sy1 = {~stop_input_n, ~prog_input_four_n, ~prog_input_three_n,
                      ~prog_input_two_n, ~prog_input_one_n};
      cur_next.sy2 = cur_reg.sy1;
      cur_next.act = cur_reg.sy2;
      // clear acts on the closing edge, so a held contact
      // cannot keep a fault cleared against a later trip
      cur_next.ext_d = {cur_reg.ext_d[0], cur_reg.act[3]};

      // one filter for whichever reference is in use
      // shift zero passes samples straight through; large shifts
      // trade noise rejection for a slow reference response
      ref_raw = use_current_ref ? current_ref_in : voltage_ref_in;
      cur_next.filt = cur_reg.filt + 26'({16'h0, ref_raw} << 16 >> analog_in_filter)
                      - (cur_reg.filt >> analog_in_filter);
      filt_code = cur_reg.filt[25:16];

      // current loop offset removed, below 4 mA reads as minimum
      if (use_current_ref) begin
         ref_span = `DSC_ADC_FULL - `DSC_ADC_4MA;
         ref_pos = (filt_code > `DSC_ADC_4MA) ? filt_code - `DSC_ADC_4MA : 10'h000;
      end else begin
         ref_span = `DSC_ADC_FULL;
         ref_pos = filt_code;
      end
      // signed slope covers inverse operation
      // quotient never exceeds the frequency span, so no wrap
      if (ref_max_frequency >= ref_min_frequency) begin
         prod = 27'({11'h0, ref_max_frequency - ref_min_frequency} * {17'h0, ref_pos});
         cur_next.freq = ref_min_frequency + 16'(prod / {17'h0, ref_span});
      end else begin
         prod = 27'({11'h0, ref_min_frequency - ref_max_frequency} * {17'h0, ref_pos});
         cur_next.freq = ref_min_frequency - 16'(prod / {17'h0, ref_span});
      end

      cur_next.fmon = mon_scale(output_frequency, freq_monitor_full_scale,
                                freq_monitor_range);
      // scaled load saturates at the top code instead of wrapping
      load_scaled = ({16'h0, drive_load} * {16'h0, load_scale_factor})
                    / {16'h0, `DSC_PCT_UNITY};
      cur_next.lmon = mon_scale((load_scaled > 32'h0000FFFF) ? 16'hFFFF :
                                load_scaled[15:0], load_monitor_full_scale,
                                load_monitor_range);

      // sleep control
      below = commanded_speed < low_speed_sleep_level;
      wake_speed = {1'b0, commanded_speed} >= {1'b0, low_speed_sleep_level}
                   + {1'b0, `DSC_WAKE_MARGIN};
      fb_active = wake_feedback_band != 16'h0000;
      // a band wider than the setpoint must not wrap into a wake
      if (reverse_acting) begin
         fb_lim = {1'b0, pid_setpoint} + {1'b0, wake_feedback_band};
         wake_fb = {1'b0, pid_feedback} > fb_lim;
      end else begin
         fb_lim = {1'b0, pid_setpoint} - {1'b0, wake_feedback_band};
         wake_fb = !fb_lim[16] && (pid_feedback < fb_lim[15:0]);
      end
      unique case (cur_reg.st)
         DSC_RUNNING: begin
            // timer idles while awake and not counting down
            cur_next.pre = 26'h0;
            cur_next.secs = 16'h0;
            if (start_cmd && !running && below) begin
               cur_next.st = DSC_SLEEPING;
            end else if (running && below) begin
               cur_next.st = DSC_TIMING;
            end
         end
         DSC_TIMING: begin
            // whole seconds only; a restart drops any part second
            if (!below || !running) begin
               cur_next.st = DSC_RUNNING;
            end else if (cur_reg.secs >= sleep_delay_time) begin
               cur_next.st = DSC_SLEEPING;
            end else if (cur_reg.pre == 26'(SEC_CYCLES - 1)) begin
               cur_next.pre = 26'h0;
               cur_next.secs = cur_reg.secs + 16'h0001;
            end else begin
               cur_next.pre = cur_reg.pre + 26'h1;
            end
         end
         DSC_SLEEPING: begin
            // wakes with a fresh delay, ramp is done by the speed controller
            if (wake_speed || (fb_active && wake_fb)) begin
               cur_next.st = DSC_RUNNING;
            end
         end
      endcase
      // flag follows the next state, so status has no extra lag
      cur_next.sleep = cur_next.st == DSC_SLEEPING;

      // fault: trip wins over a clear in the same cycle
      clear_req = keypad_stop;
      if (prog_four_fn == DSC_D_CLEAR) begin
         clear_req = clear_req || (cur_reg.ext_d == 2'b01);
      end else begin
         // stop contact clears only outside clear mode
         clear_req = clear_req || cur_reg.act[4];
      end
      if (clear_req) begin
         cur_next.fault = 1'b0;
      end
      if ((prog_four_fn == DSC_D_EXT_NO && cur_reg.act[3])
          || (prog_four_fn == DSC_D_EXT_NC && !cur_reg.act[3])) begin
         cur_next.fault = 1'b1;
      end
   end

   // reset leaves the drive awake with no fault latched
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cur_reg <= '0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   // terminal function decode, each legal set checked per input
   // functions not offered on an input are never decoded
   always_comb begin
      vref_select = 1'b0;
      iref_select = 1'b0;
      preset_select = 3'b000;
      local_mode = 1'b0;
      pot_decrease_fn = 1'b0;
      pot_increase_fn = 1'b0;
      reverse_start_fn = 1'b0;
      if (cur_reg.act[0]) begin
         vref_select = vref_select | (prog_one_fn == DSC_FN_VREF);
         iref_select = iref_select | (prog_one_fn == DSC_FN_IREF);
         preset_select[0] = prog_one_fn == DSC_FN_PRESET;
         local_mode = local_mode | (prog_one_fn == DSC_FN_LOCAL);
         pot_decrease_fn = prog_one_fn == DSC_FN_POT;
      end
      if (cur_reg.act[1]) begin
         vref_select = vref_select | (prog_two_fn == DSC_FN_VREF);
         iref_select = iref_select | (prog_two_fn == DSC_FN_IREF);
         preset_select[1] = prog_two_fn == DSC_FN_PRESET;
         pot_increase_fn = prog_two_fn == DSC_FN_POT;
      end
      if (cur_reg.act[2]) begin
         vref_select = vref_select | (prog_three_fn == DSC_FN_VREF);
         iref_select = iref_select | (prog_three_fn == DSC_FN_IREF);
         preset_select[2] = prog_three_fn == DSC_FN_PRESET;
         local_mode = local_mode | (prog_three_fn == DSC_FN_LOCAL);
         reverse_start_fn = prog_three_fn == DSC_FN_REVSTART;
      end
      // local select only counts when the strip picks the mode
      local_mode = local_mode & strip_mode_choice;
   end

   // status mirrors the sleep state for the display
   assign sleep_active = cur_reg.sleep;
   assign sleep_status = cur_reg.sleep;
   assign ref_frequency = cur_reg.freq;
   assign freq_monitor_out = cur_reg.fmon;
   assign load_monitor_out = cur_reg.lmon;
   assign fault_active = cur_reg.fault;
endmodule

// ===== shared/dsc_pkg.sv
package dsc_pkg;
   typedef enum logic [2:0] {
      DSC_FN_NONE, DSC_FN_VREF, DSC_FN_IREF, DSC_FN_PRESET, DSC_FN_LOCAL,
      DSC_FN_POT, DSC_FN_REVSTART
   } dsc_fn_e;
   typedef enum logic [1:0] {DSC_D_EXT_NO, DSC_D_EXT_NC, DSC_D_CLEAR} dsc_fn4_e;
   typedef enum logic [1:0] {DSC_MON_NONE, DSC_MON_0_10, DSC_MON_2_10} dsc_mon_e;
   typedef enum logic [1:0] {DSC_RUNNING, DSC_TIMING, DSC_SLEEPING} dsc_state_e;
endpackage

// ===== shared/dsc_regs.svh
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH
// frequencies in 0.01 Hz units, analog codes 10 bits
`define DSC_WAKE_MARGIN 16'h00C8
`define DSC_CLK_HZ 40000000
`define DSC_SEC_CYCLES (`DSC_CLK_HZ)
`define DSC_ADC_FULL 10'h3FF
`define DSC_ADC_4MA 10'h0CC
`define DSC_DAC_FULL 10'h3FF
`define DSC_DAC_2V 10'h0CC
`define DSC_PCT_UNITY 16'h0064
`endif

// ===== test/dsc_core_assertions.sv
`timescale 1ns/1ps
module dsc_core_assertions
   import dsc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [15:0] commanded_speed,
   input wire logic [15:0] low_speed_sleep_level,
   input wire logic [15:0] wake_feedback_band,
   input wire logic [15:0] pid_feedback,
   input wire logic [15:0] pid_setpoint,
   input wire logic reverse_acting,
   input wire logic [9:0] voltage_ref_in,
   input wire logic use_current_ref,
   input wire logic [3:0] analog_in_filter,
   input wire logic [15:0] ref_min_frequency,
   input wire logic [15:0] ref_max_frequency,
   input wire logic [15:0] output_frequency,
   input wire dsc_pkg::dsc_mon_e freq_monitor_range,
   input wire logic [15:0] freq_monitor_full_scale,
   input wire logic sleep_active,
   input wire logic sleep_status,
   input wire logic [15:0] ref_frequency,
   input wire logic [9:0] freq_monitor_out
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // unfiltered reference held long enough to pass filter and output stages
   sequence s_ref_held(logic [9:0] code);
      (analog_in_filter == 4'h0 && !use_current_ref && voltage_ref_in == code
         && $stable(ref_min_frequency) && $stable(ref_max_frequency)) [*3];
   endsequence
   a_ref_low_end: assert property (s_ref_held(10'h000)
      |=> ref_frequency == $past(ref_min_frequency))
      else $error("low reference not at minimum frequency");
   a_ref_top_end: assert property (s_ref_held(10'h3FF)
      |=> ref_frequency == $past(ref_max_frequency))
      else $error("full reference not at maximum frequency");
   a_status_shown: assert property (sleep_status == sleep_active)
      else $error("sleep status differs from sleep state");
   a_speed_wake: assert property (sleep_active && wake_feedback_band == 16'h0000
      && {1'b0, commanded_speed} >= {1'b0, low_speed_sleep_level} + 17'h000C8 |=> !sleep_active)
      else $error("no wake at threshold plus margin");
   a_fb_wake_low: assert property (sleep_active && wake_feedback_band != 16'h0000
      && !reverse_acting && {1'b0, pid_feedback} + wake_feedback_band < {1'b0, pid_setpoint}
      |=> !sleep_active) else $error("no wake on low feedback");
   a_fb_wake_high: assert property (sleep_active && wake_feedback_band != 16'h0000
      && reverse_acting && {1'b0, pid_feedback} > {1'b0, pid_setpoint} + wake_feedback_band
      |=> !sleep_active) else $error("no wake on high feedback");
   a_stay_awake: assert property (!sleep_active && commanded_speed >= low_speed_sleep_level
      |=> !sleep_active) else $error("sleep entered at or above threshold");
   a_mon_off: assert property (freq_monitor_range == DSC_MON_NONE |=> freq_monitor_out == 10'h000)
      else $error("disabled frequency monitor not zero");
   a_mon_full: assert property (freq_monitor_range == DSC_MON_0_10 && output_frequency != 16'h0000
      && output_frequency == freq_monitor_full_scale |=> freq_monitor_out == 10'h3FF)
      else $error("full-scale frequency not at top code");
endmodule
bind dsc_core dsc_core_assertions dsc_core_assertions_i (.*);

// ===== test/dsc_strip_model.sv
`timescale 1ns/1ps
module dsc_strip_model (
   input wire logic [3:0] closed,
   input wire logic stop_closed,
   output logic [3:0] pin_n,
   output logic stop_n
);
   // an open contact floats to the pull-up level
   assign pin_n = ~closed;
   assign stop_n = ~stop_closed;
endmodule

// ===== test/test_dsc_core.sv
`timescale 1ns/1ps
module test_dsc_core;
   import dsc_pkg::*;
   logic mclk = 0, reset_n = 0, reverse_acting = 0, running = 0, start_cmd = 0;
   logic use_current_ref = 0, strip_mode_choice = 1, keypad_stop = 0, stop_closed = 0;
   logic [15:0] commanded_speed = 0, low_speed_sleep_level = 16'h05DC, sleep_delay_time = 16'h0003;
   logic [15:0] wake_feedback_band = 0, pid_feedback = 0, pid_setpoint = 0, output_frequency = 0;
   logic [15:0] ref_min_frequency = 0, ref_max_frequency = 0, freq_monitor_full_scale = 0;
   logic [15:0] drive_load = 0, load_scale_factor = 16'h0064, load_monitor_full_scale = 16'h0064;
   logic [9:0] voltage_ref_in = 0, current_ref_in = 0, freq_monitor_out, load_monitor_out;
   logic [3:0] analog_in_filter = 0, closed = 0;
   dsc_mon_e freq_monitor_range = DSC_MON_NONE, load_monitor_range = DSC_MON_NONE;
   dsc_fn_e prog_one_fn = DSC_FN_NONE, prog_two_fn = DSC_FN_NONE, prog_three_fn = DSC_FN_NONE;
   dsc_fn4_e prog_four_fn = DSC_D_CLEAR;
   logic sleep_active, sleep_status, vref_select, iref_select, local_mode, pot_decrease_fn;
   logic pot_increase_fn, reverse_start_fn, fault_active;
   logic [15:0] ref_frequency;
   logic [2:0] preset_select;
   wire prog_input_one_n, prog_input_two_n, prog_input_three_n, prog_input_four_n, stop_input_n;
   wire [6:0] fn_out = {reverse_start_fn, pot_increase_fn, pot_decrease_fn, local_mode,
      |preset_select, iref_select, vref_select};
   int errors = 0, samples_checked = 0, cyc = 0;
   dsc_core #(.SEC_CYCLES(10)) dsc_core_i (.*);
   dsc_strip_model dsc_strip_model_i (.closed(closed), .stop_closed(stop_closed),
      .pin_n({prog_input_four_n, prog_input_three_n, prog_input_two_n, prog_input_one_n}),
      .stop_n(stop_input_n));
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         conclude();
      end
   end
   task conclude();
      $display("checks=%0d errors=%0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // inputs always move 2 ns after the edge
   task step(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task ref_case(input logic [15:0] lo, hi, input logic [9:0] v, c, input logic cur,
      input logic [15:0] exp);
      ref_min_frequency = lo;
      ref_max_frequency = hi;
      voltage_ref_in = v;
      current_ref_in = c;
      use_current_ref = cur;
      step(5);
      chk(ref_frequency, exp);
   endtask
   task t_ref();
      ref_case(16'h0BB8, 16'h1770, 10'h000, 10'h3FF, 1'b0, 16'h0BB8);
      ref_case(16'h0BB8, 16'h1770, 10'h3FF, 10'h000, 1'b0, 16'h1770);
      ref_case(16'h0BB8, 16'h1770, 10'h3FF, 10'h0CC, 1'b1, 16'h0BB8);
      ref_case(16'h0BB8, 16'h1770, 10'h000, 10'h3FF, 1'b1, 16'h1770);
      ref_case(16'h0000, 16'h3FF0, 10'h200, 10'h000, 1'b0, 16'h2000);
      ref_case(16'h1770, 16'h0BB8, 10'h3FF, 10'h000, 1'b0, 16'h0BB8);
      ref_case(16'h0000, 16'h3FF0, 10'h000, 10'h000, 1'b0, 16'h0000);
      analog_in_filter = 4'h1;
      voltage_ref_in = 10'h200;
      step(2);
      chk(ref_frequency, 16'h1000);
      step(30);
      chk(ref_frequency, 16'h2000);
      analog_in_filter = 4'h0;
      $display("t_ref done");
   endtask
   task t_mon();
      freq_monitor_range = DSC_MON_0_10;
      freq_monitor_full_scale = 16'h2EE0;
      output_frequency = 16'h2EE0;
      load_monitor_range = DSC_MON_2_10;
      step(3);
      chk(16'(freq_monitor_out), 16'h03FF);
      chk(16'(load_monitor_out), 16'h00CC);
      drive_load = 16'h004B;
      load_scale_factor = 16'h00C8;
      load_monitor_full_scale = 16'h0096;
      freq_monitor_range = DSC_MON_NONE;
      step(3);
      chk(16'(load_monitor_out), 16'h03FF);
      chk(16'(freq_monitor_out), 16'h0000);
      freq_monitor_range = DSC_MON_2_10;
      output_frequency = 16'h0000;
      step(3);
      chk(16'(freq_monitor_out), 16'h00CC);
      $display("t_mon done");
   endtask
   task pin_case(input dsc_fn_e f1, f2, f3, input logic [3:0] cl, input logic [6:0] exp);
      prog_one_fn = f1;
      prog_two_fn = f2;
      prog_three_fn = f3;
      closed = cl;
      step(5);
      chk({9'h000, fn_out}, {9'h000, exp});
   endtask
   task t_pins();
      pin_case(DSC_FN_VREF, DSC_FN_NONE, DSC_FN_NONE, 4'h1, 7'h01);
      pin_case(DSC_FN_IREF, DSC_FN_NONE, DSC_FN_NONE, 4'h1, 7'h02);
      pin_case(DSC_FN_PRESET, DSC_FN_NONE, DSC_FN_NONE, 4'h1, 7'h04);
      pin_case(DSC_FN_LOCAL, DSC_FN_NONE, DSC_FN_NONE, 4'h1, 7'h08);
      pin_case(DSC_FN_LOCAL, DSC_FN_NONE, DSC_FN_NONE, 4'h0, 7'h00);
      pin_case(DSC_FN_POT, DSC_FN_NONE, DSC_FN_NONE, 4'h1, 7'h10);
      pin_case(DSC_FN_NONE, DSC_FN_POT, DSC_FN_NONE, 4'h2, 7'h20);
      pin_case(DSC_FN_NONE, DSC_FN_PRESET, DSC_FN_NONE, 4'h2, 7'h04);
      pin_case(DSC_FN_NONE, DSC_FN_IREF, DSC_FN_VREF, 4'h6, 7'h03);
      pin_case(DSC_FN_NONE, DSC_FN_NONE, DSC_FN_REVSTART, 4'h4, 7'h40);
      pin_case(DSC_FN_NONE, DSC_FN_NONE, DSC_FN_LOCAL, 4'h4, 7'h08);
      pin_case(DSC_FN_NONE, DSC_FN_NONE, DSC_FN_NONE, 4'h7, 7'h00);
      $display("t_pins done");
   endtask
   task four_case(input dsc_fn4_e f, input logic [3:0] cl, input logic st, kp, exp);
      prog_four_fn = f;
      closed = cl;
      stop_closed = st;
      keypad_stop = kp;
      step(6);
      chk({15'h0000, fault_active}, {15'h0000, exp});
   endtask
   task t_fault();
      four_case(DSC_D_EXT_NO, 4'h8, 1'b0, 1'b0, 1'b1);
      four_case(DSC_D_EXT_NO, 4'h0, 1'b1, 1'b0, 1'b0);
      four_case(DSC_D_EXT_NC, 4'h0, 1'b0, 1'b0, 1'b1);
      four_case(DSC_D_CLEAR, 4'h0, 1'b1, 1'b0, 1'b1);
      four_case(DSC_D_CLEAR, 4'h8, 1'b0, 1'b0, 1'b0);
      four_case(DSC_D_EXT_NO, 4'h8, 1'b0, 1'b0, 1'b1);
      four_case(DSC_D_CLEAR, 4'h8, 1'b0, 1'b1, 1'b0);
      keypad_stop = 0;
      $display("t_fault done");
   endtask
   task t_sleep();
      running = 1;
      commanded_speed = 16'h0064;
      step(20);
      chk(16'(sleep_active), 16'h0000);
      commanded_speed = 16'h05DC;
      step(1);
      commanded_speed = 16'h0064;
      step(25);
      chk(16'(sleep_active), 16'h0000);
      step(15);
      chk(16'(sleep_status), 16'h0001);
      commanded_speed = 16'h06A3;
      step(3);
      chk(16'(sleep_active), 16'h0001);
      commanded_speed = 16'h06A4;
      step(2);
      chk(16'(sleep_active), 16'h0000);
      commanded_speed = 16'h0064;
      wake_feedback_band = 16'h0005;
      pid_setpoint = 16'h0032;
      pid_feedback = 16'h0032;
      step(40);
      chk(16'(sleep_active), 16'h0001);
      pid_feedback = 16'h002C;
      step(2);
      chk(16'(sleep_active), 16'h0000);
      reverse_acting = 1;
      pid_feedback = 16'h0032;
      step(40);
      chk(16'(sleep_active), 16'h0001);
      pid_feedback = 16'h0038;
      step(2);
      chk(16'(sleep_active), 16'h0000);
      running = 0;
      wake_feedback_band = 0;
      step(3);
      start_cmd = 1;
      step(1);
      start_cmd = 0;
      step(2);
      chk(16'(sleep_active), 16'h0001);
      step(3);
      chk(16'(sleep_active), 16'h0001);
      $display("t_sleep done");
   endtask
   initial begin
      step(6);
      reset_n = 1;
      step(2);
      t_ref();
      t_mon();
      t_pins();
      t_fault();
      t_sleep();
      conclude();
   end
endmodule
